// [hmrfuc_host.sv]
// Host model: issues byte strobes as the serial engine would for a host.
// Assumes the caller waits for load done; early strobes are dropped.
`timescale 1ns/100ps
`default_nettype none
module hmrfuc_host (
    input wire logic clk_sys,
    input wire logic reg_rvalid,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr = 8'h00,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_wdata = 8'h00
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Reads one byte, or two back to back when n is 2; unanswered bytes come back unknown
    task automatic rd(input logic [7:0] a, input int n,
                      output logic [7:0] hi, output logic [7:0] lo);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        if (n == 2) begin
            reg_addr <= a + 8'h01;
            #1;
            hi = reg_rvalid ? reg_rdata : 8'hxx;
            @(posedge clk_sys);
        end
        reg_rd <= 1'b0;
        #1;
        lo = reg_rvalid ? reg_rdata : 8'hxx;
    endtask
    // Both hour bytes in one block read keeps them coherent
endmodule
`default_nettype wire

// [hmrfuc_nv_store.sv]
// Small non-volatile word store standing in for the device's EEPROM cells.
// Contents ignore srst; only factory_clear returns them to factory state.
`timescale 1ns/100ps
`default_nettype none
module hmrfuc_nv_store
    import hmrfuc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic factory_clear,
    input wire logic wr_en,
    input wire logic [HMRFUC_NV_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [HMRFUC_NV_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] mem [0:HMRFUC_NV_DEPTH-1];

    // No reset here on purpose: the cells must survive every reset
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (factory_clear) begin
                for (int i = 0; i < HMRFUC_NV_DEPTH; i++) begin
                    mem[i] <= HMRFUC_NV_FACTORY;
                end
            end else if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_data <= HMRFUC_NV_FACTORY;
        end else if (ce && rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule
`default_nettype wire

// [hmrfuc_pkg.sv]
// Constants, field layout and load sequencer states of the hour meter,
// conversion ready flags and user control register group.
// Assumes the serial engine presents byte addresses as printed.
package hmrfuc_pkg;

    localparam logic [7:0] HMRFUC_OFS_HOURS_HIGH = 8'hFB;
    localparam logic [7:0] HMRFUC_OFS_HOURS_LOW = 8'hFC;
    localparam logic [7:0] HMRFUC_OFS_READY = 8'hFD;
    localparam logic [7:0] HMRFUC_OFS_USER = 8'hFE;

    localparam int HMRFUC_HOURS_FAULT_BIT = 7;
    localparam int HMRFUC_HOURS_HI_MSB = 6;
    localparam int HMRFUC_HOURS_WIDTH = 15;

    localparam int HMRFUC_READY_COUNT = 5;
    localparam int HMRFUC_READY_MSB = 7;
    localparam int HMRFUC_READY_LSB = 3;
    localparam logic [2:0] HMRFUC_READY_RSVD = 3'h0;

    localparam int HMRFUC_UC_MASK_BIT = 6;
    localparam int HMRFUC_UC_FLAG_BIT = 5;
    localparam int HMRFUC_UC_IE_BIT = 4;
    localparam int HMRFUC_UC_PSEL_MSB = 3;
    localparam int HMRFUC_UC_PSEL_LSB = 2;
    localparam int HMRFUC_UC_MSEL_MSB = 1;
    localparam int HMRFUC_UC_MSEL_LSB = 0;
    localparam logic [7:0] HMRFUC_UC_NV_MASK = 8'h5F;

    localparam logic [7:0] HMRFUC_HOURS_RESET = 8'h00;
    localparam logic [4:0] HMRFUC_READY_RESET = 5'h00;
    localparam logic [7:0] HMRFUC_UC_RESET = 8'h20;
    localparam logic [7:0] HMRFUC_NV_FACTORY = 8'h00;
    localparam logic [7:0] HMRFUC_RD_UNMAPPED = 8'h00;

    localparam int HMRFUC_NV_DEPTH = 4;
    localparam int HMRFUC_NV_AW = 2;
    localparam logic [1:0] HMRFUC_NV_HOURS_HI = 2'h0;
    localparam logic [1:0] HMRFUC_NV_HOURS_LO = 2'h1;
    localparam logic [1:0] HMRFUC_NV_USER = 2'h2;

    localparam logic [1:0] HMRFUC_SEL_ZERO = 2'h0;
    localparam logic [1:0] HMRFUC_SEL_ONE = 2'h1;
    localparam logic [1:0] HMRFUC_SEL_TWO = 2'h2;
    localparam logic [2:0] HMRFUC_ONEHOT_NONE = 3'h0;

    typedef enum logic [2:0] {
        HMRFUC_LD_HI = 3'b000,
        HMRFUC_LD_LO = 3'b001,
        HMRFUC_LD_UC = 3'b011,
        HMRFUC_LD_LAST = 3'b010,
        HMRFUC_RUN = 3'b110
    } hmrfuc_load_t;

endpackage

// [hmrfuc_regs.sv]
// Hour meter, conversion ready flags and user control register group.
// Assumes a serial engine on clk_sys that issues one-cycle byte strobes
// and reports reads of the result registers as one-cycle pulses.
// Operation
// - Hour count is fifteen bits, split high/low.
// - High byte bit seven flags corrupted hours.
// - Hour meter bytes live in non-volatile cells.
// - Factory state of both hour bytes is zero.
// - Finished conversion sets its data ready flag.
// - Reading a result clears only its flag.
// - Ready flags sit in bits seven to three.
// - Power selector picks one of three setpoints.
// - Modulation selector picks one of three setpoints.
// - Interrupt pin asserts only with global enable.
// - Writing enable high while asserted releases pin.
// - Power-on sets flag; mask raises an interrupt.
// - Reading user control clears flag and its interrupt.
// - Late mask with flag set asserts pin at once.
// - Mask, enable and selectors kept non-volatile.
// - Codes zero to two decode; three is reserved.
`timescale 1ns/100ps
`default_nettype none
module hmrfuc_regs
    import hmrfuc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic factory_clear,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic reg_ready,
    output logic reg_hit,
    output logic reg_rvalid,
    output logic [7:0] reg_rdata,
    input wire logic [HMRFUC_READY_COUNT-1:0] conv_done,
    input wire logic [HMRFUC_READY_COUNT-1:0] result_read,
    input wire logic ext_int_pending,
    output logic int_n_out,
    output logic int_n_oe,
    output logic [HMRFUC_HOURS_WIDTH-1:0] hours_count,
    output logic hour_meter_fault,
    output logic [1:0] power_setpoint_select,
    output logic [1:0] modulation_setpoint_select,
    output logic [2:0] power_setpoint_onehot,
    output logic [2:0] modulation_setpoint_onehot
);

    hmrfuc_load_t load_reg;
    hmrfuc_load_t load_next;
    logic [7:0] hours_high_byte_reg;
    logic [7:0] hours_low_byte_reg;
    logic [HMRFUC_READY_COUNT-1:0] ready_reg;
    logic [HMRFUC_READY_COUNT-1:0] ready_next;
    logic [7:0] user_nv_reg;
    logic [7:0] user_nv_next;
    logic flag_reg;
    logic flag_next;
    logic squelch_reg;
    logic squelch_next;
    logic pending_reg;
    logic pending_next;
    logic int_oe_reg;
    logic int_oe_next;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic [2:0] psel_onehot_reg;
    logic [2:0] msel_onehot_reg;
    logic hit_hi;
    logic hit_lo;
    logic hit_ready;
    logic hit_user;
    logic wr_go;
    logic rd_go;
    logic [7:0] rd_mux;
    logic [7:0] user_view;
    logic nv_rd_en;
    logic [HMRFUC_NV_AW-1:0] nv_rd_addr;
    logic [7:0] nv_rd_data;
    logic nv_wr_en;
    logic [HMRFUC_NV_AW-1:0] nv_wr_addr;
    logic [7:0] nv_wr_data;
    hmrfuc_nv_store u_nv (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .factory_clear(factory_clear),
        .wr_en(nv_wr_en),
        .wr_addr(nv_wr_addr),
        .wr_data(nv_wr_data),
        .rd_en(nv_rd_en),
        .rd_addr(nv_rd_addr),
        .rd_data(nv_rd_data)
    );
    assign hit_hi = (reg_addr == HMRFUC_OFS_HOURS_HIGH);
    assign hit_lo = (reg_addr == HMRFUC_OFS_HOURS_LOW);
    assign hit_ready = (reg_addr == HMRFUC_OFS_READY);
    assign hit_user = (reg_addr == HMRFUC_OFS_USER);
    assign reg_hit = hit_hi | hit_lo | hit_ready | hit_user;
    // Host access waits until the cells have been copied to the shadows
    assign reg_ready = (load_reg == HMRFUC_RUN);
    assign wr_go = ce & reg_ready & reg_wr;
    assign rd_go = ce & reg_ready & reg_rd & ~reg_wr;
    // Load sequence after reset: read, then capture one word later
    always_comb begin
        load_next = load_reg;
        nv_rd_en = 1'b0;
        nv_rd_addr = HMRFUC_NV_HOURS_HI;
        unique case (load_reg)
            HMRFUC_LD_HI: begin
                nv_rd_en = 1'b1;
                nv_rd_addr = HMRFUC_NV_HOURS_HI;
                load_next = HMRFUC_LD_LO;
            end
            HMRFUC_LD_LO: begin
                nv_rd_en = 1'b1;
                nv_rd_addr = HMRFUC_NV_HOURS_LO;
                load_next = HMRFUC_LD_UC;
            end
            HMRFUC_LD_UC: begin
                nv_rd_en = 1'b1;
                nv_rd_addr = HMRFUC_NV_USER;
                load_next = HMRFUC_LD_LAST;
            end
            HMRFUC_LD_LAST: begin
                load_next = HMRFUC_RUN;
            end
            HMRFUC_RUN: begin
                load_next = HMRFUC_RUN;
            end
            default: begin
                load_next = HMRFUC_LD_HI;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            load_reg <= HMRFUC_LD_HI;
        end else if (ce) begin
            // A factory clear reloads the shadows from the fresh cells
            load_reg <= factory_clear ? HMRFUC_LD_HI : load_next;
        end
    end
    // Every host write to a persistent byte goes straight to the cells
    always_comb begin
        nv_wr_en = wr_go & (hit_hi | hit_lo | hit_user);
        nv_wr_addr = HMRFUC_NV_HOURS_HI;
        nv_wr_data = reg_wdata;
        if (hit_lo) begin
            nv_wr_addr = HMRFUC_NV_HOURS_LO;
        end else if (hit_user) begin
            nv_wr_addr = HMRFUC_NV_USER;
            nv_wr_data = reg_wdata & HMRFUC_UC_NV_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hours_high_byte_reg <= HMRFUC_HOURS_RESET;
        end else if (ce) begin
            if (load_reg == HMRFUC_LD_LO) begin
                hours_high_byte_reg <= nv_rd_data;
            end else if (wr_go && hit_hi) begin
                hours_high_byte_reg <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hours_low_byte_reg <= HMRFUC_HOURS_RESET;
        end else if (ce) begin
            if (load_reg == HMRFUC_LD_UC) begin
                hours_low_byte_reg <= nv_rd_data;
            end else if (wr_go && hit_lo) begin
                hours_low_byte_reg <= reg_wdata;
            end
        end
    end

    assign hours_count = {hours_high_byte_reg[HMRFUC_HOURS_HI_MSB:0],
        hours_low_byte_reg};
    assign hour_meter_fault = hours_high_byte_reg[HMRFUC_HOURS_FAULT_BIT];
    // A completion in the same cycle as a clear or a write wins
    always_comb begin
        if (wr_go && hit_ready) begin
            ready_next = reg_wdata[HMRFUC_READY_MSB:HMRFUC_READY_LSB];
        end else begin
            ready_next = ready_reg & ~result_read;
        end
        ready_next = ready_next | conv_done;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ready_reg <= HMRFUC_READY_RESET;
        end else if (ce) begin
            ready_reg <= ready_next;
        end
    end
    // Persistent user control bits and the power-on flag
    always_comb begin
        user_nv_next = user_nv_reg;
        if (load_reg == HMRFUC_LD_LAST) begin
            user_nv_next = nv_rd_data & HMRFUC_UC_NV_MASK;
        end else if (wr_go && hit_user) begin
            user_nv_next = reg_wdata & HMRFUC_UC_NV_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            user_nv_reg <= HMRFUC_UC_RESET & HMRFUC_UC_NV_MASK;
        end else if (ce) begin
            user_nv_reg <= user_nv_next;
        end
    end

    always_comb begin
        flag_next = flag_reg;
        if (wr_go && hit_user) begin
            flag_next = reg_wdata[HMRFUC_UC_FLAG_BIT];
        end else if (rd_go && hit_user) begin
            flag_next = 1'b0;
        end
    end

    // srst is the power-on event, so it is what raises the flag
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flag_reg <= HMRFUC_UC_RESET[HMRFUC_UC_FLAG_BIT];
        end else if (ce) begin
            flag_reg <= flag_next;
        end
    end

    // Interrupt sources, quieting and the open-drain pin
    always_comb begin
        pending_next = (flag_next & user_nv_next[HMRFUC_UC_MASK_BIT])
            | ext_int_pending;
        squelch_next = squelch_reg;
        if (wr_go & hit_user & reg_wdata[HMRFUC_UC_IE_BIT] & int_oe_reg) begin
            squelch_next = 1'b1;
        end else if (!pending_next || (pending_next && !pending_reg)) begin
            // A fresh source after quieting may assert the pin again
            squelch_next = 1'b0;
        end
        int_oe_next = user_nv_next[HMRFUC_UC_IE_BIT] & pending_next
            & ~squelch_next;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pending_reg <= 1'b0;
            squelch_reg <= 1'b0;
        end else if (ce) begin
            pending_reg <= pending_next;
            squelch_reg <= squelch_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            int_oe_reg <= 1'b0;
        end else if (ce) begin
            int_oe_reg <= int_oe_next;
        end
    end

    assign int_n_out = 1'b0;
    assign int_n_oe = int_oe_reg;
    // Selectors; code three drives no setpoint rather than guessing one
    assign power_setpoint_select =
        user_nv_reg[HMRFUC_UC_PSEL_MSB:HMRFUC_UC_PSEL_LSB];
    assign modulation_setpoint_select =
        user_nv_reg[HMRFUC_UC_MSEL_MSB:HMRFUC_UC_MSEL_LSB];
    function automatic logic [2:0] hmrfuc_decode(input logic [1:0] sel);
        logic [2:0] onehot;
        onehot = HMRFUC_ONEHOT_NONE;
        unique case (sel)
            HMRFUC_SEL_ZERO: onehot = 3'h1;
            HMRFUC_SEL_ONE: onehot = 3'h2;
            HMRFUC_SEL_TWO: onehot = 3'h4;
            default: onehot = HMRFUC_ONEHOT_NONE;
        endcase
        return onehot;
    endfunction
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            psel_onehot_reg <= HMRFUC_ONEHOT_NONE;
            msel_onehot_reg <= HMRFUC_ONEHOT_NONE;
        end else if (ce) begin
            psel_onehot_reg <= hmrfuc_decode(user_nv_next[HMRFUC_UC_PSEL_MSB:
                HMRFUC_UC_PSEL_LSB]);
            msel_onehot_reg <= hmrfuc_decode(user_nv_next[HMRFUC_UC_MSEL_MSB:
                HMRFUC_UC_MSEL_LSB]);
        end
    end

    assign power_setpoint_onehot = psel_onehot_reg;
    assign modulation_setpoint_onehot = msel_onehot_reg;
    // Read path; reserved bits return zero
    always_comb begin
        user_view = user_nv_reg;
        user_view[HMRFUC_UC_FLAG_BIT] = flag_reg;
        rd_mux = HMRFUC_RD_UNMAPPED;
        if (hit_hi) begin
            rd_mux = hours_high_byte_reg;
        end else if (hit_lo) begin
            rd_mux = hours_low_byte_reg;
        end else if (hit_ready) begin
            rd_mux = {ready_reg, HMRFUC_READY_RSVD};
        end else if (hit_user) begin
            rd_mux = user_view;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_reg <= HMRFUC_RD_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else if (ce) begin
            rvalid_reg <= rd_go;
            if (rd_go) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
endmodule
`default_nettype wire

// [hmrfuc_regs_checker.sv]
// Assertion checker for the hour meter, ready flag and user control group.
// Sees only the top ports; bound to hmrfuc_regs from the testbench top.
`timescale 1ns/100ps
`default_nettype none
module hmrfuc_regs_checker (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_ready,
    input wire logic reg_rvalid,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] conv_done,
    input wire logic [4:0] result_read,
    input wire logic ext_int_pending,
    input wire logic int_n_oe,
    input wire logic [14:0] hours_count,
    input wire logic hour_meter_fault,
    input wire logic [1:0] power_setpoint_select,
    input wire logic [1:0] modulation_setpoint_select,
    input wire logic [2:0] power_setpoint_onehot,
    input wire logic [2:0] modulation_setpoint_onehot
);
    wire logic rd_ok = ce && reg_ready && reg_rd && !reg_wr;
    wire logic wr_ok = ce && reg_ready && reg_wr;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_rd(logic [7:0] a);
        rd_ok && reg_addr == a;
    endsequence
    sequence s_wr_fe;
        wr_ok && reg_addr == 8'hFE;
    endsequence
    // Two stable cycles so a registered decode has settled
    property p_dec(logic [1:0] s, logic [2:0] h);
        reg_ready && $stable(s) ##1 $stable(s)
            |-> h == (s == 2'h3 ? 3'h0 : 3'h1 << s);
    endproperty
    a_hours_high: assert property (
        s_rd(8'hFB) |=> reg_rvalid
            && reg_rdata == {hour_meter_fault, hours_count[14:8]})
        else $error("hours high byte read wrong");
    a_ready_set: assert property (
        ce && conv_done[4] ##1 !result_read[4] && !wr_ok ##1 s_rd(8'hFD)
            |=> reg_rdata[7]) else $error("ready flag not set");
    a_ready_clear: assert property (
        ce && result_read[4] && !conv_done[4] && !wr_ok
            ##1 !conv_done[4] && !wr_ok ##1 s_rd(8'hFD)
            |=> !reg_rdata[7]) else $error("ready flag not cleared");
    a_ie_gates: assert property (
        reg_rvalid && !reg_rdata[4] && $past(rd_ok && reg_addr == 8'hFE)
            |-> !int_n_oe) else $error("pin driven with enable clear");
    a_read_clears: assert property (
        s_rd(8'hFE) and !ext_int_pending |=> !int_n_oe)
        else $error("control read left pin asserted");
    a_late_mask: assert property (
        (s_rd(8'hFE) and !ext_int_pending) ##2 (s_wr_fe
            and reg_wdata[6:4] == 3'b111 && !ext_int_pending) |=> int_n_oe)
        else $error("mask with flag set did not assert pin");
    a_ie_release: assert property (
        s_wr_fe and reg_wdata[4] && int_n_oe |=> !int_n_oe)
        else $error("enable write did not release pin");
    a_power_decode: assert property (
        p_dec(power_setpoint_select, power_setpoint_onehot))
        else $error("power selector decode wrong");
    a_mod_decode: assert property (
        p_dec(modulation_setpoint_select, modulation_setpoint_onehot))
        else $error("modulation selector decode wrong");
endmodule
`default_nettype wire

// [hmrfuc_regs_tb.sv]
// Testbench for hmrfuc_regs driven through the host model.
// Assumes the checker and host model files are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module hmrfuc_regs_tb;
    logic clk_sys, srst, ce, factory_clear, ext_int_pending;
    logic [4:0] conv_done, result_read;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, hi, lo;
    logic reg_wr, reg_rd, reg_ready, reg_rvalid, int_n_oe, fault, hit, int_out;
    logic [14:0] hours;
    logic [1:0] psel, msel;
    logic [2:0] poh, moh;
    int miscompares = 0;
    int checks = 0;
    hmrfuc_regs u_hmrfuc_regs (.clk_sys(clk_sys), .srst(srst), .ce(ce),
        .factory_clear(factory_clear), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_ready(reg_ready),
        .reg_hit(hit), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
        .conv_done(conv_done), .result_read(result_read),
        .ext_int_pending(ext_int_pending), .int_n_out(int_out),
        .int_n_oe(int_n_oe),
        .hours_count(hours), .hour_meter_fault(fault),
        .power_setpoint_select(psel), .modulation_setpoint_select(msel),
        .power_setpoint_onehot(poh), .modulation_setpoint_onehot(moh));
    hmrfuc_host u_hmrfuc_host (.clk_sys(clk_sys), .reg_rvalid(reg_rvalid),
        .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    always #12.5 clk_sys = ~clk_sys;
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_hmrfuc_host.rd(a, 1, hi, lo);
        chk(lo, e);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // Bounded, since the load takes a fixed handful of cycles
    task automatic wait_ready();
        int n;
        n = 0;
        #1;
        while (reg_ready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(reg_ready, 1'b1);
    endtask
    task automatic reset_dut();
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        wait_ready();
    endtask
    task automatic pulse(input logic [4:0] c, input logic [4:0] r);
        @(posedge clk_sys);
        conv_done <= c;
        result_read <= r;
        @(posedge clk_sys);
        conv_done <= 5'h00;
        result_read <= 5'h00;
    endtask
    task automatic wr_int(input logic [7:0] d, input logic e);
        u_hmrfuc_host.wr(8'hFE, d);
        settle();
        chk(int_n_oe, e);
    endtask
    initial begin
        #(25 * 5000);
        miscompares++;
        final_report();
    end
    initial begin
        clk_sys = 1'b0;
        srst = 1'b1;
        ce = 1'b1;
        factory_clear = 1'b0;
        ext_int_pending = 1'b0;
        conv_done = 5'h00;
        result_read = 5'h00;
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        // Cells start undefined, so program factory state before use
        @(posedge clk_sys);
        factory_clear <= 1'b1;
        @(posedge clk_sys);
        factory_clear <= 1'b0;
        wait_ready();
        u_hmrfuc_host.rd(8'hFB, 2, hi, lo);
        chk({hi, lo}, 16'h0000);
        rchk(8'hFD, 8'h00);
        chk(hit, 1'b1);
        rchk(8'hFE, 8'h20);
        rchk(8'hFE, 8'h00);
        rchk(8'h10, 8'h00);
        chk(hit, 1'b0);
        $display("test reset values done");
        u_hmrfuc_host.wr(8'hFB, 8'h85);
        u_hmrfuc_host.wr(8'hFC, 8'h3C);
        settle();
        chk(hours, 16'h053C);
        chk(fault, 1'b1);
        for (int i = 0; i < 4; i++) begin
            u_hmrfuc_host.wr(8'hFE, {4'h0, i[1:0], i[1:0]});
            settle();
            chk(psel, i[1:0]);
            chk(msel, i[1:0]);
            chk(poh, i == 3 ? 3'h0 : 3'h1 << i);
            chk(moh, i == 3 ? 3'h0 : 3'h1 << i);
        end
        u_hmrfuc_host.wr(8'hFE, 8'h06);
        reset_dut();
        u_hmrfuc_host.rd(8'hFB, 2, hi, lo);
        chk({hi, lo}, 16'h853C);
        rchk(8'hFE, 8'h26);
        $display("test hours and selectors done");
        pulse(5'h1F, 5'h00);
        rchk(8'hFD, 8'hF8);
        pulse(5'h00, 5'h10);
        rchk(8'hFD, 8'h78);
        pulse(5'h01, 5'h01);
        rchk(8'hFD, 8'h78);
        // With the clock enable low nothing may move
        @(posedge clk_sys);
        ce <= 1'b0;
        pulse(5'h10, 5'h0F);
        ce <= 1'b1;
        rchk(8'hFD, 8'h78);
        u_hmrfuc_host.wr(8'hFD, 8'h87);
        rchk(8'hFD, 8'h80);
        $display("test ready flags done");
        wr_int(8'h30, 1'b0);
        rchk(8'hFE, 8'h30);
        wr_int(8'h70, 1'b1);
        repeat (3) settle();
        chk(int_n_oe, 1'b1);
        rchk(8'hFE, 8'h70);
        chk(int_n_oe, 1'b0);
        @(posedge clk_sys);
        ext_int_pending <= 1'b1;
        settle();
        chk(int_n_oe, 1'b1);
        chk(int_out, 1'b0);
        wr_int(8'h10, 1'b0);
        @(posedge clk_sys);
        ext_int_pending <= 1'b0;
        u_hmrfuc_host.wr(8'hFE, 8'h00);
        @(posedge clk_sys);
        ext_int_pending <= 1'b1;
        settle();
        chk(int_n_oe, 1'b0);
        rchk(8'hFE, 8'h00);
        @(posedge clk_sys);
        ext_int_pending <= 1'b0;
        u_hmrfuc_host.wr(8'hFE, 8'h50);
        reset_dut();
        settle();
        chk(int_n_oe, 1'b1);
        rchk(8'hFE, 8'h70);
        u_hmrfuc_host.wr(8'hFE, 8'h10);
        reset_dut();
        settle();
        chk(int_n_oe, 1'b0);
        wr_int(8'h70, 1'b1);
        $display("test interrupts done");
        final_report();
    end
endmodule
bind hmrfuc_regs hmrfuc_regs_checker u_hmrfuc_regs_checker (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_ready(reg_ready), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .result_read(result_read),
    .ext_int_pending(ext_int_pending), .int_n_oe(int_n_oe),
    .hours_count(hours_count), .hour_meter_fault(hour_meter_fault),
    .power_setpoint_select(power_setpoint_select),
    .modulation_setpoint_select(modulation_setpoint_select),
    .power_setpoint_onehot(power_setpoint_onehot),
    .modulation_setpoint_onehot(modulation_setpoint_onehot));
`default_nettype wire
